// ### verilog/usart_pkg.sv
package usart_pkg;

  // Register byte addresses (offsets are not multiples of four, so index times four).
  localparam logic [7:0] IDX_CTRL_STAT = 8'hBA;
  localparam logic [7:0] IDX_RX_STAT = 8'hBB;
  localparam logic [7:0] IDX_IRQ_CLK = 8'hBC;
  localparam logic [11:0] ADDR_CTRL_STAT = {2'h0, IDX_CTRL_STAT, 2'h0};
  localparam logic [11:0] ADDR_RX_STAT = {2'h0, IDX_RX_STAT, 2'h0};
  localparam logic [11:0] ADDR_IRQ_CLK = {2'h0, IDX_IRQ_CLK, 2'h0};
  localparam logic [11:0] ADDR_TX_HOLD = 12'h300;
  localparam logic [11:0] ADDR_RX_HOLD = 12'h304;
  localparam logic [11:0] ADDR_BAUD_DIV = 12'h308;

  // uart_control_status field positions.
  localparam int CS_PARITY_EN = 7;
  localparam int CS_PSEL_HI = 6;
  localparam int CS_PSEL_LO = 5;
  localparam int CS_LEN_HI = 4;
  localparam int CS_LEN_LO = 3;
  localparam int CS_ERR = 2;
  localparam int CS_RX_FULL = 1;
  localparam int CS_TX_EMPTY = 0;

  // receive_control_status field positions.
  localparam int RS_OVERRUN = 7;
  localparam int RS_FRAMING = 6;
  localparam int RS_PARITY = 5;
  localparam int RS_SPARE = 4;
  localparam int RS_NINTH = 3;
  localparam int RS_ADDRESS_WAKE_MODE = 2;
  localparam int RS_TX_ACTIVE = 1;
  localparam int RS_BREAK = 0;

  // interrupt_clock_source field positions.
  localparam int IC_TWO_STOP = 7;
  localparam int IC_SHORT_STOP = 6;
  localparam int IC_PIN_EN = 5;
  localparam int IC_SYNC = 4;
  localparam int IC_RX_EXT = 3;
  localparam int IC_TX_EXT = 2;
  localparam int IC_RX_IRQ = 1;
  localparam int IC_TX_IRQ = 0;

  // Frame length codes.
  localparam logic [1:0] LEN_8 = 2'h0;
  localparam logic [1:0] LEN_7 = 2'h1;
  localparam logic [1:0] LEN_9 = 2'h2;
  localparam logic [1:0] LEN_LOOP = 2'h3;

  // Oversampling figures.
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_HALF = 4'h7;
  localparam logic [3:0] OVS_SHORT_LAST = 4'hD;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [15:0] BAUD_RESET = 16'h0001;

endpackage : usart_pkg

// ### verilog/usart_core.sv
`timescale 1ns/1ps
// Behaviour
// R01 - Parity only with enable, 7/8-bit frames
// R02 - Parity select: odd, even, mark, space
// R03 - Low select bit is ninth tx bit
// R04 - Length bits: 8, 7, 9 data bits
// R05 - Length 11 loops tx to rx, 9-bit
// R06 - Summary error flag from any error
// R07 - Receive full set on copy, read clears
// R08 - Tx empty set on load, write clears
// R09 - Sticky errors cleared by status read
// R10 - Software writes zero to spare bit
// R11 - Ninth received bit captured in status
// R12 - Attention cleared by ninth bit one
// R13 - Tx active until last stop ends
// R14 - Break status on framing error, clears high
// R15 - One or two stops, short last stop
// R16 - Serial out driven only when enabled
// R17 - Async 16x clock, sync 1x clock
// R18 - Per-direction external clock select
// R19 - Separate rx and tx interrupt enables
// R20 - Double-buffered transmit holding register
// R21 - Start verified at half bit, mid-bit samples
// R22 - Sync: launch rising, capture falling
// R23 - Receiver needs only one stop bit
// R24 - Interrupts pending while flag and enable
// R25 - Framing on low stop, overrun on full
module usart_core (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Serial pins.
  input wire logic serial_in_pin_i,
  input wire logic ext_bit_clock_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_oe_o,
  output logic ext_bit_clock_o,
  // Interrupts.
  output logic rx_irq_o,
  output logic tx_irq_o
);

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} usart_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} usart_rx_e;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rstat;
    logic [7:0] icfg;
    logic [15:0] baud_div;
    logic [15:0] baud_cnt;
    logic baud_tick;
    logic [1:0] rx_sync;
    logic [1:0] ck_sync;
    logic ck_prev;
    logic int_clk;
    logic [7:0] tx_hold;
    logic [9:0] tx_shifter;
    logic [3:0] tx_cnt;
    logic [3:0] tx_bit;
    logic tx_stop2;
    logic tx_line;
    usart_tx_e tx_state;
    logic [8:0] rx_shifter;
    logic [3:0] rx_cnt;
    logic [3:0] rx_bit;
    usart_rx_e rx_state;
    logic [7:0] rx_hold;
    logic [31:0] rdata;
  } usart_state_s;

  usart_state_s state_reg;
  usart_state_s state_next;

  // Number of payload bits (data plus parity) for the current length code.
  function automatic logic [3:0] usart_payload(input logic [1:0] len, input logic par_en);
    logic [3:0] n;
    n = (len == usart_pkg::LEN_7) ? 4'h7 : ((len[1]) ? 4'h9 : 4'h8); // see R04 see R05
    if (!len[1] && par_en) begin
      n = n + 4'h1; // see R01
    end
    return n;
  endfunction : usart_payload

  // Parity bit for data with the select bits.
  function automatic logic usart_parity(input logic [7:0] d, input logic [1:0] sel,
                                        input logic [1:0] len);
    logic p;
    p = (len == usart_pkg::LEN_7) ? ^d[6:0] : ^d;
    unique case (sel) // see R02
      2'h0: usart_parity = ~p;
      2'h1: usart_parity = p;
      2'h2: usart_parity = 1'b1;
      2'h3: usart_parity = 1'b0;
    endcase
  endfunction : usart_parity

  logic access;
  logic wr;
  logic rd;
  logic tx_tick;
  logic rx_tick;
  logic ck_rise;
  logic ck_fall;
  logic int_rise;
  logic int_fall;
  logic [1:0] len;
  logic sync_mode;
  logic rx_line;
  logic [3:0] payload;
  logic [3:0] stop_last;

  // APB control: zero wait states, every access answers in the access phase.
  assign access = psel_i && penable_i;
  assign wr = access && pwrite_i;
  assign rd = access && !pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign prdata_o = state_reg.rdata;

  // Shared decoding of mode and clocks.
  assign len = {state_reg.ctrl[usart_pkg::CS_LEN_HI], state_reg.ctrl[usart_pkg::CS_LEN_LO]};
  assign sync_mode = state_reg.icfg[usart_pkg::IC_SYNC];
  assign payload = usart_payload(len, state_reg.ctrl[usart_pkg::CS_PARITY_EN]);
  assign ck_rise = state_reg.ck_sync[1] && !state_reg.ck_prev;
  assign ck_fall = !state_reg.ck_sync[1] && state_reg.ck_prev;
  assign int_rise = state_reg.baud_tick && !state_reg.int_clk;
  assign int_fall = state_reg.baud_tick && state_reg.int_clk;
  assign stop_last = state_reg.icfg[usart_pkg::IC_SHORT_STOP] ?
                     usart_pkg::OVS_SHORT_LAST : usart_pkg::OVS_LAST; // see R15

  // Bit clocks: async uses each external rising edge or baud tick as a 16x tick, sync launches on rise.
  always_comb begin
    if (state_reg.icfg[usart_pkg::IC_TX_EXT]) begin // see R18
      tx_tick = sync_mode ? ck_rise : ck_rise; // see R17 see R22
    end else begin
      tx_tick = sync_mode ? int_rise : state_reg.baud_tick;
    end
    if (state_reg.icfg[usart_pkg::IC_RX_EXT]) begin // see R18
      rx_tick = sync_mode ? ck_fall : ck_rise; // see R22
    end else begin
      rx_tick = sync_mode ? int_fall : state_reg.baud_tick;
    end
  end

  // Loopback feeds the receiver from the transmitter line.
  assign rx_line = (len == usart_pkg::LEN_LOOP) ? state_reg.tx_line
                                                : state_reg.rx_sync[1]; // see R05

  // Outputs.
  assign serial_out_pin_o = state_reg.tx_line;
  assign serial_out_oe_o = state_reg.icfg[usart_pkg::IC_PIN_EN]; // see R16
  assign ext_bit_clock_o = state_reg.int_clk;
  assign rx_irq_o = state_reg.ctrl[usart_pkg::CS_RX_FULL]
                    && state_reg.icfg[usart_pkg::IC_RX_IRQ]; // see R19 see R24
  assign tx_irq_o = state_reg.ctrl[usart_pkg::CS_TX_EMPTY]
                    && state_reg.icfg[usart_pkg::IC_TX_IRQ]; // see R19 see R24

  // Next-state logic for registers, baud source, transmitter and receiver.
  always_comb begin
    logic rx_done;
    logic fe;
    logic pe;
    logic oe;
    logic tx_load;
    logic [3:0] stop_len;
    rx_done = 1'b0;
    fe = 1'b0;
    pe = 1'b0;
    oe = 1'b0;
    tx_load = 1'b0;
    stop_len = usart_pkg::OVS_LAST;
    state_next = state_reg;

    // Synchronisers and internal baud divider.
    state_next.rx_sync = {state_reg.rx_sync[0], serial_in_pin_i};
    state_next.ck_sync = {state_reg.ck_sync[0], ext_bit_clock_pin_i};
    state_next.ck_prev = state_reg.ck_sync[1];
    state_next.baud_tick = 1'b0;
    if (state_reg.baud_cnt >= state_reg.baud_div) begin
      state_next.baud_cnt = 16'h0000;
      state_next.baud_tick = 1'b1;
    end else begin
      state_next.baud_cnt = state_reg.baud_cnt + 16'h0001;
    end
    if (int_rise || int_fall) begin
      state_next.int_clk = !state_reg.int_clk;
    end

    // Transmitter.
    unique case (state_reg.tx_state)
      TX_IDLE: begin
        if (!state_reg.ctrl[usart_pkg::CS_TX_EMPTY] && (tx_tick || !sync_mode)) begin // see R22
          tx_load = 1'b1;
        end
      end
      TX_START: begin
        if (tx_tick) begin
          state_next.tx_cnt = state_reg.tx_cnt + 4'h1;
          if (sync_mode || state_reg.tx_cnt == usart_pkg::OVS_LAST) begin
            state_next.tx_cnt = 4'h0;
            state_next.tx_state = TX_BITS;
            state_next.tx_line = state_reg.tx_shifter[0];
          end
        end
      end
      TX_BITS: begin
        if (tx_tick) begin
          state_next.tx_cnt = state_reg.tx_cnt + 4'h1;
          if (sync_mode || state_reg.tx_cnt == usart_pkg::OVS_LAST) begin
            state_next.tx_cnt = 4'h0;
            state_next.tx_shifter = {1'b1, state_reg.tx_shifter[9:1]};
            state_next.tx_line = state_reg.tx_shifter[1];
            state_next.tx_bit = state_reg.tx_bit + 4'h1;
            if (state_reg.tx_bit + 4'h1 == payload) begin
              state_next.tx_state = TX_STOP;
              state_next.tx_line = 1'b1;
              state_next.tx_stop2 = state_reg.icfg[usart_pkg::IC_TWO_STOP]; // see R15
            end
          end
        end
      end
      TX_STOP: begin
        stop_len = state_reg.tx_stop2 ? usart_pkg::OVS_LAST : stop_last;
        if (tx_tick) begin
          state_next.tx_cnt = state_reg.tx_cnt + 4'h1;
          if (sync_mode || state_reg.tx_cnt == stop_len) begin
            state_next.tx_cnt = 4'h0;
            if (state_reg.tx_stop2) begin
              state_next.tx_stop2 = 1'b0;
            end else if (!state_reg.ctrl[usart_pkg::CS_TX_EMPTY]) begin
              tx_load = 1'b1; // see R20
            end else begin
              state_next.tx_state = TX_IDLE; // see R13
            end
          end
        end
      end
    endcase
    // Move the holding register into the shifter and raise the empty flag.
    if (tx_load) begin
      state_next.tx_shifter = {1'b1, 1'b1, state_reg.tx_hold};
      if (len[1]) begin
        state_next.tx_shifter[8] = state_reg.ctrl[usart_pkg::CS_PSEL_LO]; // see R03
      end else if (state_reg.ctrl[usart_pkg::CS_PARITY_EN]) begin
        state_next.tx_shifter[payload - 4'h1] = usart_parity(state_reg.tx_hold,
          {state_reg.ctrl[usart_pkg::CS_PSEL_HI], state_reg.ctrl[usart_pkg::CS_PSEL_LO]},
          len); // see R01 see R02
      end
      state_next.ctrl[usart_pkg::CS_TX_EMPTY] = 1'b1; // see R08 see R20
      state_next.tx_state = TX_START;
      state_next.tx_line = 1'b0;
      state_next.tx_bit = 4'h0;
      state_next.tx_cnt = 4'h0;
    end
    state_next.rstat[usart_pkg::RS_TX_ACTIVE] = (state_next.tx_state != TX_IDLE); // see R13

    // Receiver.
    unique case (state_reg.rx_state)
      RX_IDLE: begin
        if (!rx_line) begin
          state_next.rx_state = RX_START;
          state_next.rx_cnt = 4'h0;
          state_next.rx_bit = 4'h0;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          state_next.rx_cnt = state_reg.rx_cnt + 4'h1;
          if (sync_mode || state_reg.rx_cnt == usart_pkg::OVS_HALF) begin
            state_next.rx_cnt = 4'h0;
            state_next.rx_state = rx_line ? RX_IDLE : RX_BITS; // see R21
          end
        end
      end
      RX_BITS: begin
        if (rx_tick) begin
          state_next.rx_cnt = state_reg.rx_cnt + 4'h1;
          if (sync_mode || state_reg.rx_cnt == usart_pkg::OVS_LAST) begin
            state_next.rx_cnt = 4'h0;
            state_next.rx_bit = state_reg.rx_bit + 4'h1;
            if (state_reg.rx_bit == payload) begin
              rx_done = 1'b1; // see R23
              state_next.rx_state = RX_IDLE;
              fe = !rx_line; // see R25
            end else begin
              state_next.rx_shifter[state_reg.rx_bit] = rx_line; // see R21
            end
          end
        end
      end
      default: state_next.rx_state = RX_IDLE;
    endcase
    if (rx_done) begin
      oe = state_reg.ctrl[usart_pkg::CS_RX_FULL]; // see R25
      if (!len[1] && state_reg.ctrl[usart_pkg::CS_PARITY_EN]) begin
        pe = state_reg.rx_shifter[payload - 4'h1] != usart_parity(state_reg.rx_shifter[7:0],
          {state_reg.ctrl[usart_pkg::CS_PSEL_HI], state_reg.ctrl[usart_pkg::CS_PSEL_LO]},
          len); // see R01
      end
      state_next.rx_hold = (len == usart_pkg::LEN_7) ? {1'b0, state_reg.rx_shifter[6:0]}
                                                     : state_reg.rx_shifter[7:0];
    end

    // Register writes and read side effects; hardware sets win over clears, but a holding write clears tx empty over a load.
    if (wr) begin
      unique case (paddr_i)
        usart_pkg::ADDR_CTRL_STAT: begin
          state_next.ctrl[7:3] = pwdata_i[7:3];
        end
        usart_pkg::ADDR_RX_STAT: begin
          state_next.rstat[usart_pkg::RS_SPARE] = pwdata_i[usart_pkg::RS_SPARE]; // see R10
          state_next.rstat[usart_pkg::RS_ADDRESS_WAKE_MODE] = pwdata_i[usart_pkg::RS_ADDRESS_WAKE_MODE];
        end
        usart_pkg::ADDR_IRQ_CLK: state_next.icfg = pwdata_i[7:0];
        usart_pkg::ADDR_TX_HOLD: begin
          state_next.tx_hold = pwdata_i[7:0];
          state_next.ctrl[usart_pkg::CS_TX_EMPTY] = 1'b0; // see R08
        end
        usart_pkg::ADDR_BAUD_DIV: state_next.baud_div = pwdata_i[15:0];
        default: ;
      endcase
    end
    if (rd && paddr_i == usart_pkg::ADDR_RX_STAT) begin
      state_next.rstat[7:5] = state_reg.rstat[7:5] & ~state_reg.rdata[7:5]; // see R09
    end
    if (rd && paddr_i == usart_pkg::ADDR_RX_HOLD) begin
      state_next.ctrl[usart_pkg::CS_RX_FULL] = 1'b0; // see R07
    end
    if (rx_done) begin
      state_next.ctrl[usart_pkg::CS_RX_FULL] = 1'b1; // see R07
      state_next.rstat[usart_pkg::RS_OVERRUN] = state_next.rstat[usart_pkg::RS_OVERRUN] | oe;
      state_next.rstat[usart_pkg::RS_FRAMING] = state_next.rstat[usart_pkg::RS_FRAMING] | fe;
      state_next.rstat[usart_pkg::RS_PARITY] = state_next.rstat[usart_pkg::RS_PARITY] | pe;
      if (len[1]) begin
        state_next.rstat[usart_pkg::RS_NINTH] = state_reg.rx_shifter[8]; // see R11
        if (state_reg.rx_shifter[8]) begin
          state_next.rstat[usart_pkg::RS_ADDRESS_WAKE_MODE] = 1'b0; // see R12
        end
      end
    end
    // Line status follows framing errors until the line returns high.
    if (fe) begin
      state_next.rstat[usart_pkg::RS_BREAK] = 1'b1; // see R14
    end else if (rx_line) begin
      state_next.rstat[usart_pkg::RS_BREAK] = 1'b0; // see R14
    end
    state_next.ctrl[usart_pkg::CS_ERR] = |state_next.rstat[7:5]; // see R06

    // Read data, registered so it is valid during the access phase.
    state_next.rdata = 32'h0000_0000;
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        usart_pkg::ADDR_CTRL_STAT: state_next.rdata[7:0] = state_reg.ctrl;
        usart_pkg::ADDR_RX_STAT: state_next.rdata[7:0] = state_reg.rstat;
        usart_pkg::ADDR_IRQ_CLK: state_next.rdata[7:0] = state_reg.icfg;
        usart_pkg::ADDR_TX_HOLD: state_next.rdata[7:0] = state_reg.tx_hold;
        usart_pkg::ADDR_RX_HOLD: state_next.rdata[7:0] = state_reg.rx_hold;
        usart_pkg::ADDR_BAUD_DIV: state_next.rdata[15:0] = state_reg.baud_div;
        default: ;
      endcase
    end
  end

  // State register; the transmit line idles high.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
      state_reg.ctrl <= usart_pkg::CTRL_RESET;
      state_reg.baud_div <= usart_pkg::BAUD_RESET;
      state_reg.rx_sync <= 2'h3;
      state_reg.tx_shifter <= 10'h3FF;
      state_reg.tx_line <= 1'b1;
      state_reg.tx_state <= TX_IDLE;
      state_reg.rx_state <= RX_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : usart_core

// ### test/usart_core_monitor.sv
`timescale 1ns/1ps
module usart_core_monitor (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Bus side.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  // Line and interrupt side.
  input wire logic serial_in_pin_i,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_oe_o,
  input wire logic rx_irq_o,
  input wire logic tx_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic acc;
  logic wr_ic;
  logic rd_rx;
  logic [7:0] ic_reg;
  logic [9:0] quiet_reg;
  // Access phase qualifiers.
  assign acc = psel_i && penable_i;
  assign wr_ic = acc && pwrite_i && paddr_i == usart_pkg::ADDR_IRQ_CLK;
  assign rd_rx = acc && !pwrite_i && paddr_i == usart_pkg::ADDR_RX_STAT;
  // Enable shadow and idle count; a long idle stretch means no character can land mid-read.
  // Limitation: the idle bound suits small baud divisors only.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ic_reg <= 8'h00;
      quiet_reg <= 10'h000;
    end else begin
      if (wr_ic) begin
        ic_reg <= pwdata_i[7:0];
      end
      if (!(serial_in_pin_i && serial_out_pin_o)) begin
        quiet_reg <= 10'h000;
      end else if (quiet_reg != 10'h3FF) begin
        quiet_reg <= quiet_reg + 10'h001;
      end
    end
  end
  a_reset_line_idle: assert property (
    $rose(nrst_i) |-> serial_out_pin_o && !serial_out_oe_o && !tx_irq_o && !rx_irq_o)
    else $error("line or interrupts not idle after reset");
  a_pin_enable_set: assert property (
    wr_ic |=> serial_out_oe_o == $past(pwdata_i[usart_pkg::IC_PIN_EN]))
    else $error("pin enable does not follow the write");
  a_pin_enable_hold: assert property (
    !wr_ic |=> $stable(serial_out_oe_o))
    else $error("pin enable changed without a write");
  a_tx_irq_gate: assert property (
    !ic_reg[usart_pkg::IC_TX_IRQ] && !$past(ic_reg[usart_pkg::IC_TX_IRQ]) |-> !tx_irq_o)
    else $error("transmit interrupt while disabled");
  a_rx_irq_gate: assert property (
    !ic_reg[usart_pkg::IC_RX_IRQ] && !$past(ic_reg[usart_pkg::IC_RX_IRQ]) |-> !rx_irq_o)
    else $error("receive interrupt while disabled");
  a_status_read_clears: assert property (
    (quiet_reg == 10'h3FF && rd_rx) ##[1:4] rd_rx |-> prdata_o[7:5] == 3'h0)
    else $error("error flags survive a status read");
  a_hold_read_clears: assert property (
    (quiet_reg == 10'h3FF && acc && !pwrite_i && paddr_i == usart_pkg::ADDR_RX_HOLD)
    ##[1:4] (acc && !pwrite_i && paddr_i == usart_pkg::ADDR_CTRL_STAT)
    |-> !prdata_o[usart_pkg::CS_RX_FULL])
    else $error("receive full survives a holding read");
  a_break_clears: assert property (
    serial_in_pin_i [*8] ##0 rd_rx |-> !prdata_o[usart_pkg::RS_BREAK])
    else $error("break status stays with the line high");
endmodule : usart_core_monitor

bind usart_core usart_core_monitor mon_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .serial_in_pin_i(serial_in_pin_i),
  .serial_out_pin_o(serial_out_pin_o), .serial_out_oe_o(serial_out_oe_o),
  .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));

// ### test/usart_remote.sv
`timescale 1ns/1ps
module usart_remote #(
  parameter int BIT_CYC = 32
) (
  // Clock.
  input wire logic clk_i,
  // Line towards the block.
  output logic line_o,
  // Line from the block.
  input wire logic dut_tx_i,
  input wire logic dut_oe_i
);
  logic rx_line;
  logic [9:0] got_frame;
  int got_count;
  // An undriven pin is pulled up, so a disabled output reads as idle.
  assign rx_line = dut_oe_i ? dut_tx_i : 1'b1;
  initial begin
    line_o = 1'b1;
    got_frame = 10'h000;
    got_count = 0;
  end
  // Sends twelve bit times, bit 0 first; the line keeps the last level afterwards.
  task automatic send(input logic [11:0] bits);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_i);
      line_o <= bits[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask : send
  // Samples ten bits at mid-bit after each start; stopping early keeps back-to-back frames of eleven bits or more.
  always begin
    @(negedge rx_line);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      got_frame[i] = rx_line;
    end
    got_count++;
  end
endmodule : usart_remote

// ### test/usart_sync_async_core_tb.sv
`timescale 1ns/1ps
module usart_sync_async_core_tb;
  // Baud divisor 1 ticks every two clocks, sixteen ticks a bit.
  localparam int BIT_CYC = 32;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, serial_in_pin_i, serial_out_pin_o, serial_out_oe_o;
  logic ext_clk_o, rx_irq_o, tx_irq_o;
  logic [31:0] q;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  always #2 core_clk_i = ~core_clk_i;
  usart_core dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .serial_in_pin_i(serial_in_pin_i), .ext_bit_clock_pin_i(1'b0),
    .serial_out_pin_o(serial_out_pin_o), .serial_out_oe_o(serial_out_oe_o),
    .ext_bit_clock_o(ext_clk_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));
  usart_remote #(.BIT_CYC(BIT_CYC)) rem_u (.clk_i(core_clk_i), .line_o(serial_in_pin_i),
    .dut_tx_i(serial_out_pin_o), .dut_oe_i(serial_out_oe_o));
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // A hang is cut short well past the expected run length.
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
    chk(pslverr_o, 32'h0);
  endtask : rd_chk
  task automatic wait_frames(input int n);
    for (int k = 0; k < 1000 && rem_u.got_count < n; k++) @(posedge core_clk_i);
    chk(rem_u.got_count, n);
  endtask : wait_frames
  // Expected line bits after the start bit: data, then parity or ninth bit, then stop.
  function automatic logic [9:0] frame_bits(logic [7:0] c, logic [7:0] d);
    logic [9:0] f;
    logic [7:0] m;
    int n;
    f = 10'h3FF;
    n = (c[4:3] == usart_pkg::LEN_7) ? 7 : 8;
    m = (n == 7) ? {1'b0, d[6:0]} : d;
    f[7:0] = m;
    f[n] = 1'b1;
    if (c[4:3] == usart_pkg::LEN_9) f[8] = c[5];
    else if (c[7]) f[n] = c[6] ? ~c[5] : (^m) ^ ~c[5];
    return f;
  endfunction : frame_bits
  task automatic t_regs();
    rd_chk(usart_pkg::ADDR_CTRL_STAT, usart_pkg::CTRL_RESET);
    rd_chk(usart_pkg::ADDR_RX_STAT, 8'h00);
    rd_chk(usart_pkg::ADDR_IRQ_CLK, 8'h00);
    apb(1'b1, usart_pkg::ADDR_CTRL_STAT, 8'hFF);
    rd_chk(usart_pkg::ADDR_CTRL_STAT, 8'hF9);
    apb(1'b1, usart_pkg::ADDR_RX_STAT, 8'hEF);
    rd_chk(usart_pkg::ADDR_RX_STAT, 8'h04);
    apb(1'b1, usart_pkg::ADDR_IRQ_CLK, 8'hFF);
    @(negedge core_clk_i);
    chk({rx_irq_o, tx_irq_o}, 32'h1);
    apb(1'b1, usart_pkg::ADDR_IRQ_CLK, 8'hFE);
    @(negedge core_clk_i);
    chk(tx_irq_o, 32'h0);
    apb(1'b1, 12'h010, 8'h5A);
    rd_chk(12'h010, 8'h00);
    apb(1'b1, usart_pkg::ADDR_RX_STAT, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_formats();
    logic [7:0] cfg [7] = '{8'h00, 8'h80, 8'hA0, 8'hC8, 8'hE8, 8'hB0, 8'h10};
    int n0;
    apb(1'b1, usart_pkg::ADDR_IRQ_CLK, 8'h20);
    for (int i = 0; i < 7; i++) begin
      n0 = rem_u.got_count;
      apb(1'b1, usart_pkg::ADDR_CTRL_STAT, cfg[i]);
      apb(1'b1, usart_pkg::ADDR_TX_HOLD, 8'hA5 + 8'(i));
      rd_chk(usart_pkg::ADDR_RX_STAT, 8'h02);
      wait_frames(n0 + 1);
      chk(rem_u.got_frame, frame_bits(cfg[i], 8'hA5 + 8'(i)));
      repeat (BIT_CYC) @(posedge core_clk_i);
      rd_chk(usart_pkg::ADDR_RX_STAT, 8'h00);
    end
    $display("test formats done");
  endtask : t_formats
  task automatic t_dbuf();
    int n0;
    n0 = rem_u.got_count;
    apb(1'b1, usart_pkg::ADDR_CTRL_STAT, 8'h00);
    apb(1'b1, usart_pkg::ADDR_IRQ_CLK, 8'hA0);
    apb(1'b1, usart_pkg::ADDR_TX_HOLD, 8'h81);
    apb(1'b1, usart_pkg::ADDR_TX_HOLD, 8'h7E);
    rd_chk(usart_pkg::ADDR_CTRL_STAT, 8'h00);
    wait_frames(n0 + 1);
    chk(rem_u.got_frame, 10'h381);
    repeat (BIT_CYC) @(posedge core_clk_i);
    rd_chk(usart_pkg::ADDR_CTRL_STAT, 8'h01);
    wait_frames(n0 + 2);
    chk(rem_u.got_frame, 10'h37E);
    $display("test double buffer done");
  endtask : t_dbuf
  task automatic t_rx();
    apb(1'b1, usart_pkg::ADDR_IRQ_CLK, 8'h22);
    apb(1'b1, usart_pkg::ADDR_CTRL_STAT, 8'hA0);
    rem_u.send({2'h3, ^8'h5A, 8'h5A, 1'b0});
    @(negedge core_clk_i);
    chk(rx_irq_o, 32'h1);
    rd_chk(usart_pkg::ADDR_CTRL_STAT, 8'hA3);
    rd_chk(usart_pkg::ADDR_RX_HOLD, 8'h5A);
    rd_chk(usart_pkg::ADDR_CTRL_STAT, 8'hA1);
    rem_u.send({2'h3, ^8'h11, 8'h11, 1'b0});
    rem_u.send({2'h3, ^8'h22, 8'h22, 1'b0});
    rd_chk(usart_pkg::ADDR_RX_STAT, 8'h80);
    apb(1'b0, usart_pkg::ADDR_RX_HOLD, 8'h00);
    rem_u.send({3'h0, ~(^8'h33), 8'h33, 1'b0});
    rd_chk(usart_pkg::ADDR_RX_STAT, 8'h61);
    rem_u.send(12'hFFF);
    repeat (1100) @(posedge core_clk_i);
    apb(1'b0, usart_pkg::ADDR_RX_HOLD, 8'h00);
    rd_chk(usart_pkg::ADDR_CTRL_STAT, 8'hA5);
    apb(1'b0, usart_pkg::ADDR_RX_STAT, 8'h00);
    rd_chk(usart_pkg::ADDR_RX_STAT, 8'h00);
    $display("test receive done");
  endtask : t_rx
  task automatic t_nine();
    apb(1'b1, usart_pkg::ADDR_CTRL_STAT, 8'h10);
    apb(1'b1, usart_pkg::ADDR_RX_STAT, 8'h04);
    rem_u.send({3'h7, 8'h3C, 1'b0});
    rd_chk(usart_pkg::ADDR_RX_STAT, 8'h08);
    rd_chk(usart_pkg::ADDR_RX_HOLD, 8'h3C);
    $display("test ninth bit done");
  endtask : t_nine
  task automatic t_loop();
    apb(1'b1, usart_pkg::ADDR_IRQ_CLK, 8'h00);
    apb(1'b1, usart_pkg::ADDR_CTRL_STAT, 8'h38);
    apb(1'b1, usart_pkg::ADDR_TX_HOLD, 8'h5C);
    for (int k = 0; k < 200 && q[1] !== 1'b1; k++) apb(1'b0, usart_pkg::ADDR_CTRL_STAT, 8'h00);
    rd_chk(usart_pkg::ADDR_RX_HOLD, 8'h5C);
    repeat (BIT_CYC) @(posedge core_clk_i);
    rd_chk(usart_pkg::ADDR_RX_STAT, 8'h08);
    $display("test loopback done");
  endtask : t_loop
  task automatic t_sync();
    apb(1'b1, usart_pkg::ADDR_IRQ_CLK, 8'h10);
    apb(1'b1, usart_pkg::ADDR_TX_HOLD, 8'hC3);
    repeat (2 * BIT_CYC) @(posedge core_clk_i);
    rd_chk(usart_pkg::ADDR_RX_HOLD, 8'hC3);
    $display("test sync done");
  endtask : t_sync
  // Main sequence: reset for sixteen cycles, then each scenario in turn.
  initial begin
    q = 32'h0;
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_formats();
    t_dbuf();
    t_rx();
    t_nine();
    t_loop();
    t_sync();
    stop_test();
  end
endmodule : usart_sync_async_core_tb
